// file: hdl/e1dni_core.sv
/*
 * e1dni_core: E1/T1 timeslot drop-and-insert with receive buffer clock
 * selection, overhead channel placement and service channel baud limits.
 * Assumes link pins are asynchronous to sys_clk and run far below 12.5 MHz.
 */
// The APB register port and the register offsets were chosen for this implementation.
// Operation
// - equal rates: buffer clock from tx or external
// - unequal rates: synthesised clock locked to reference
// - X.21: DTE ignores rx clock, DCE tx
// - service channel in bytes 16, 48, half 32
// - no service channel in CAS mode
// - power control in byte 0 first bit
// - baud capped by lower data rate
// - rate change lowers baud automatically
// - service and power control for E1 only
// - E1 timeslots 1 to 31, 0 rejected
// - T1 timeslots 1 to 24 or unused
// - channel count is rate over 64k
// - 1920 kbps uses fixed timeslot equals channel plus one
// - standard satellite rate is 16/15
// - reduced framing: up to 24 channels, 46/45
// - reduced framing carries no CAS
// - loop feeds drop stream into insert input
// - looped stream timeslots overwritten by satellite data
// - insert reference: recovered insert clock and data
// - insert dead or unframed: fall back demod (in T1 an active insert always counts as framed)
// - otherwise insert ignored, blank frame generated
// - buffer off: clock from demodulator
`timescale 1ns/100ps
module e1dni_core (
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                srst,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// e1/t1 pins
	input  wire logic                drop_clk,
	input  wire logic                drop_input,
	input  wire logic                insert_clk,
	input  wire logic                insert_input,
	output logic                     drop_output,
	output logic                     insert_output,
	output logic                     insert_clk_out,
	// clock references
	input  wire logic                tx_ref_clk,
	input  wire logic                ext_ref_clk,
	input  wire logic                demod_tick,
	output logic                     buf_clk,
	output e1dni_pkg::e1dni_ref_t    buf_ref,
	// satellite datapath
	output e1dni_pkg::e1dni_sat_t    sat_tx,
	input  wire e1dni_pkg::e1dni_sat_t sat_rx,
	// overhead placement
	input  wire logic [5:0]          ovh_idx,
	input  wire logic [2:0]          ovh_bit,
	output logic                     ovh_esc,
	output logic                     ovh_uplink_power_control
);
	import e1dni_pkg::*;

	localparam int NP = 6;
	localparam int P_DCLK = 0;
	localparam int P_DDAT = 1;
	localparam int P_ICLK = 2;
	localparam int P_IDAT = 3;
	localparam int P_TXC  = 4;
	localparam int P_EXT  = 5;

	function automatic e1dni_pos_t pos_of(input logic [7:0] cnt, input logic t1);
		logic [7:0] m;
		m = cnt - 8'h01;
		if (!t1)
			pos_of = '{ts: cnt[7:3], bitn: cnt[2:0]};
		else if (cnt == 8'h00)
			pos_of = '{ts: 5'h00, bitn: 3'h7};
		else
			pos_of = '{ts: 5'(m[7:3] + 5'h01), bitn: m[2:0]};
	endfunction : pos_of

	function automatic logic [7:0] next_cnt(input logic [7:0] cnt, input logic t1);
		next_cnt = (t1 && cnt == T1_LAST) ? 8'h00 : 8'(cnt + 8'h01);
	endfunction : next_cnt

	function automatic e1dni_hit_t chan_of(input logic [4:0] ts, input logic [31:0][4:0] map,
			input logic [5:0] count, input logic fixed);
		e1dni_hit_t h;
		h = '{hit: 1'b0, chan: 5'h00};
		if (fixed) begin
			h.hit  = (ts != 5'h00) && ({1'b0, ts} <= count);
			h.chan = 5'(ts - 5'h01);
		end else begin
			for (int c = 0; c < 32; c++) begin
				if (6'(c) < count && map[c] == ts && ts != 5'h00 && !h.hit) begin
					h.hit  = 1'b1;
					h.chan = 5'(c);
				end
			end
		end
		chan_of = h;
	endfunction : chan_of

	// max baud code from 64k units: 0=2400 .. 6=38400
	function automatic logic [2:0] baud_cap(input logic [5:0] u);
		if (u >= 6'd20)      baud_cap = 3'h6;
		else if (u >= 6'd12) baud_cap = 3'h5;
		else if (u >= 6'd8)  baud_cap = 3'h4;
		else if (u >= 6'd6)  baud_cap = 3'h3;
		else if (u >= 6'd4)  baud_cap = 3'h2;
		else if (u >= 6'd2)  baud_cap = 3'h1;
		else                 baud_cap = 3'h0;
	endfunction : baud_cap

	// pin synchronisers
	logic [NP-1:0] s1, s2, s3, pin_f, pin_fq;
	logic [NP-1:0] pin_rise;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			pin_f <= '0;
			pin_fq <= '0;
		end else begin
			s1 <= {ext_ref_clk, tx_ref_clk, insert_input, insert_clk, drop_input, drop_clk};
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < NP; i++) begin
				if (s2[i] == s3[i])
					pin_f[i] <= s3[i];
			end
			pin_fq <= pin_f;
		end
	end
	assign pin_rise = pin_f & ~pin_fq;

	// registers
	logic [CTL_W-1:0] ctrl;
	logic [5:0]       tx_rate, rx_rate;
	logic [2:0]       esc_baud;
	logic [15:0]      nco_inc;
	logic [31:0][4:0] tx_map, rx_map;
	logic             map_err;
	logic [7:0]       rx_buf [32];

	logic       dni_en, t1, cas_eff, reduced, loop_en, x21, x21_dte, ext_sel;
	logic [1:0] buf_mode;
	logic       hesc_active, uplink_power_control_active;
	logic [5:0] min_rate, tx_cnt, rx_cnt, max_ch;
	logic [2:0] cap;
	assign dni_en   = ctrl[CTL_DNI];
	assign t1       = ctrl[CTL_T1];
	assign reduced  = ctrl[CTL_REDUCED];
	assign cas_eff  = ctrl[CTL_CAS] & ~reduced;
	assign loop_en  = ctrl[CTL_LOOP];
	assign buf_mode = ctrl[CTL_BUF_LO +: 2];
	assign x21      = ctrl[CTL_X21];
	assign x21_dte  = ctrl[CTL_X21_DTE];
	assign ext_sel  = ctrl[CTL_EXT_SEL];
	assign hesc_active = dni_en & ~t1 & ~cas_eff & ctrl[CTL_HESC];
	// power control is only honoured on top of the earlier settings
	assign uplink_power_control_active = hesc_active & ctrl[CTL_UPLINK_POWER_CONTROL];
	assign min_rate = (tx_rate < rx_rate) ? tx_rate : rx_rate;
	assign cap      = baud_cap(min_rate);
	assign max_ch   = reduced ? MAX_T1_CH : (t1 ? MAX_T1_CH : MAX_E1_CH);
	assign tx_cnt   = (tx_rate > max_ch) ? max_ch : tx_rate;
	assign rx_cnt   = (rx_rate > max_ch) ? max_ch : rx_rate;

	// apb: pready rises in the second access cycle; a transfer completes there
	logic        acc, wr, setup;
	logic [11:0] a;
	logic        map_ok, tx_map_hit, rx_map_hit;
	logic [4:0]  wv;
	assign setup = psel & penable & ~pready;
	assign acc   = psel & penable & pready;
	assign wr    = acc & pwrite;
	assign a     = {paddr[11:2], 2'b00};
	assign wv    = pwdata[4:0];
	assign tx_map_hit = a[11:7] == OFS_TX_MAP[11:7];
	assign rx_map_hit = a[11:7] == OFS_RX_MAP[11:7];
	assign map_ok = t1 ? (wv <= MAX_T1_TS) : (wv != 5'h00);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl    <= CTRL_RST;
			tx_rate <= RATE_RST;
			rx_rate <= RATE_RST;
			nco_inc <= NCO_INC_RST;
			tx_map  <= '0;
			rx_map  <= '0;
		end else if (wr) begin
			case (a)
				OFS_CTRL:    ctrl    <= pwdata[CTL_W-1:0];
				OFS_TX_RATE: tx_rate <= pwdata[5:0];
				OFS_RX_RATE: rx_rate <= pwdata[5:0];
				OFS_NCO_INC: nco_inc <= pwdata[15:0];
				default: begin
					if (tx_map_hit && map_ok)
						tx_map[a[6:2]] <= wv;
					if (rx_map_hit && map_ok)
						rx_map[a[6:2]] <= wv;
				end
			endcase
		end
	end

	// baud follows writes, then is pulled down whenever the cap drops
	always_ff @(posedge sys_clk) begin
		if (srst)
			esc_baud <= BAUD_RST;
		else if (wr && a == OFS_ESC_BAUD)
			esc_baud <= (pwdata[2:0] > cap) ? cap : pwdata[2:0];
		else if (esc_baud > cap)
			esc_baud <= cap;
	end

	// map error: a new rejection wins over a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (srst)
			map_err <= 1'b0;
		else if (wr && (tx_map_hit || rx_map_hit) && !map_ok)
			map_err <= 1'b1;
		else if (wr && a == OFS_ERR_CLR && pwdata[0])
			map_err <= 1'b0;
	end

	logic       ins_active, ilock, dlock;
	logic [7:0] sat_num, sat_den;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (setup) begin
				case (a)
					OFS_CTRL:     prdata <= 32'(ctrl);
					OFS_TX_RATE:  prdata <= 32'(tx_rate);
					OFS_RX_RATE:  prdata <= 32'(rx_rate);
					OFS_ESC_BAUD: prdata <= 32'(esc_baud);
					OFS_NCO_INC:  prdata <= 32'(nco_inc);
					OFS_STATUS:   prdata <= {sat_den, sat_num, 7'h00, uplink_power_control_active,
						hesc_active, map_err, dlock, ilock, ins_active, buf_ref};
					OFS_ERR_CLR:  prdata <= 32'h0000_0000;
					default: begin
						if (tx_map_hit)
							prdata <= 32'(tx_map[a[6:2]]);
						else if (rx_map_hit)
							prdata <= 32'(rx_map[a[6:2]]);
						else
							pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	// satellite rate ratio for standard or reduced framing
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sat_num <= STD_NUM;
			sat_den <= STD_DEN;
		end else begin
			sat_num <= reduced ? RED_NUM : STD_NUM;
			sat_den <= reduced ? RED_DEN : STD_DEN;
		end
	end

	// overhead bit roles, aligned to the modulator's overhead position
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ovh_esc  <= 1'b0;
			ovh_uplink_power_control <= 1'b0;
		end else begin
			ovh_esc  <= hesc_active && (ovh_idx == OVH_ESC_A || ovh_idx == OVH_ESC_B
				|| (ovh_idx == OVH_ESC_H && ovh_bit < 3'h4));
			ovh_uplink_power_control <= uplink_power_control_active && ovh_idx == OVH_UW && ovh_bit == 3'h0;
		end
	end

	// drop path
	logic       drop_edge, dbit;
	logic [7:0] dcnt, dsr;
	e1dni_pos_t dpos;
	e1dni_hit_t dhit;
	assign drop_edge = pin_rise[P_DCLK];
	assign dbit      = pin_f[P_DDAT];
	assign dpos      = pos_of(dcnt, t1);
	assign dhit      = chan_of(dpos.ts, tx_map, tx_cnt, tx_rate == FIXED_RATE);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dcnt <= 8'h00;
			dsr <= 8'h00;
			dlock <= 1'b0;
			sat_tx <= '0;
			drop_output <= 1'b0;
		end else begin
			sat_tx.valid <= 1'b0;
			if (drop_edge) begin
				dsr <= {dsr[6:0], dbit};
				drop_output <= dbit;
				if (!t1 && {dsr[5:0], dbit} == FAS_WORD) begin
					dlock <= (dcnt == 8'h07);
					dcnt  <= 8'h08;
				end else begin
					dcnt <= next_cnt(dcnt, t1);
					if (t1)
						dlock <= 1'b1;
				end
				if (dni_en && dlock && dpos.bitn == 3'h7 && dhit.hit)
					sat_tx <= '{valid: 1'b1, chan: dhit.chan, data: {dsr[6:0], dbit}};
			end
		end
	end

	// satellite receive bytes waiting to be inserted
	always_ff @(posedge sys_clk) begin
		if (sat_rx.valid)
			rx_buf[sat_rx.chan] <= sat_rx.data;
	end

	// insert source and activity watch
	logic       src_edge, src_bit, src_lvl, follow_src, passthru;
	logic [6:0] idle_cnt;
	assign src_edge   = loop_en ? drop_edge : pin_rise[P_ICLK];
	assign src_bit    = loop_en ? dbit : pin_f[P_IDAT];
	assign src_lvl    = loop_en ? pin_f[P_DCLK] : pin_f[P_ICLK];
	assign follow_src = (buf_mode == BUF_INSERT) & ins_active;
	assign passthru   = follow_src & ilock;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			idle_cnt   <= 7'h00;
			ins_active <= 1'b0;
		end else begin
			if (src_edge)
				idle_cnt <= 7'h00;
			else if (idle_cnt != 7'(LOSS_CYC))
				idle_cnt <= 7'(idle_cnt + 7'h01);
			ins_active <= src_edge || idle_cnt < 7'(LOSS_CYC - 1);
		end
	end

	// rate synthesiser, realigned every 256 reference edges
	logic [15:0] nco;
	logic        nco_tick;
	logic [7:0]  ref_cnt;
	logic        tx_lvl, ref_edge, dm_tick;
	assign tx_lvl   = pin_f[P_TXC] & ~(x21 & ~x21_dte);
	assign ref_edge = ext_sel ? pin_rise[P_EXT] : (pin_rise[P_TXC] & ~(x21 & ~x21_dte));
	assign dm_tick  = demod_tick & ~(x21 & x21_dte);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			nco <= 16'h0000;
			nco_tick <= 1'b0;
			ref_cnt <= 8'h00;
		end else begin
			if (ref_edge)
				ref_cnt <= 8'(ref_cnt + 8'h01);
			if (ref_edge && ref_cnt == 8'hFF) begin
				nco <= 16'h0000;
				nco_tick <= 1'b0;
			end else
				{nco_tick, nco} <= 17'(nco + nco_inc);
		end
	end

	// buffer reference choice and buffer clock
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			buf_ref <= REF_DEMOD;
			buf_clk <= 1'b0;
		end else begin
			case (buf_mode)
				BUF_OFF:    buf_ref <= REF_DEMOD;
				BUF_TX_EQ:  buf_ref <= ext_sel ? REF_EXT : REF_TXCLK;
				BUF_TX_NE:  buf_ref <= REF_SYNTH;
				BUF_INSERT: buf_ref <= (ins_active && ilock) ? REF_INSERT : REF_DEMOD;
				default:    buf_ref <= REF_DEMOD;
			endcase
			case (buf_ref)
				REF_TXCLK:  buf_clk <= tx_lvl;
				REF_EXT:    buf_clk <= pin_f[P_EXT];
				REF_SYNTH:  buf_clk <= nco[15];
				REF_INSERT: buf_clk <= src_lvl;
				default:    buf_clk <= dm_tick ? ~buf_clk : buf_clk;
			endcase
		end
	end

	// insert path
	logic       ins_tick, fpar, ovr, novr;
	logic [7:0] icnt, isr, osr, nbyte;
	e1dni_pos_t ipos;
	e1dni_hit_t ihit;
	assign ins_tick = follow_src ? src_edge : nco_tick;
	assign ipos     = pos_of(icnt, t1);
	assign ihit     = chan_of(ipos.ts, rx_map, rx_cnt, rx_rate == FIXED_RATE);

	always_comb begin
		nbyte = IDLE_BYTE;
		novr  = 1'b1;
		if (dni_en && ihit.hit)
			nbyte = rx_buf[ihit.chan];
		else if (passthru)
			novr = 1'b0;
		else if (ipos.ts == 5'h00)
			nbyte = t1 ? {fpar, 7'h00} : (fpar ? NFAS_BYTE : FAS_BYTE);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			icnt <= 8'h00;
			isr <= 8'h00;
			osr <= 8'h00;
			ovr <= 1'b1;
			fpar <= 1'b0;
			ilock <= 1'b0;
			insert_output <= 1'b0;
			insert_clk_out <= 1'b0;
		end else begin
			insert_clk_out <= follow_src ? src_lvl : nco[15];
			if (!follow_src)
				ilock <= 1'b0;
			if (ins_tick) begin
				if (ipos.bitn == 3'h0 && (!t1 || icnt != 8'h00)) begin
					ovr <= novr;
					osr <= {nbyte[6:0], 1'b0};
					insert_output <= novr ? nbyte[7] : src_bit;
				end else if (t1 && icnt == 8'h00) begin
					ovr <= novr;
					insert_output <= novr ? nbyte[7] : src_bit;
				end else begin
					osr <= {osr[6:0], 1'b0};
					insert_output <= ovr ? osr[7] : src_bit;
				end
				if (follow_src && !t1 && {isr[5:0], src_bit} == FAS_WORD) begin
					ilock <= (icnt == 8'h07);
					icnt  <= 8'h08;
				end else begin
					icnt <= next_cnt(icnt, t1);
					if (follow_src && t1)
						ilock <= 1'b1;
				end
				if (next_cnt(icnt, t1) == 8'h00)
					fpar <= ~fpar;
			end
			if (src_edge)
				isr <= {isr[6:0], src_bit};
		end
	end

	// checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence apb_setup_s;
		psel && !penable;
	endsequence
	sequence apb_access_s;
		psel && penable;
	endsequence

	chk_apb_answer: assert property (apb_setup_s ##1 apb_access_s |-> ##1 pready)
		else $error("apb answer late");
	chk_ts_zero_reject: assert property (wr && tx_map_hit && !t1 && wv == 5'h00
		|=> map_err && tx_map[$past(a[6:2])] == $past(tx_map[a[6:2]]))
		else $error("timeslot zero accepted");
	chk_t1_range: assert property (wr && rx_map_hit && t1 && wv > MAX_T1_TS |=> map_err)
		else $error("t1 timeslot above range accepted");
	chk_baud_cap_hold: assert property (##1 esc_baud <= $past(cap) || $past(wr))
		else $error("baud above cap");
	chk_esc_no_cas: assert property (ovh_esc |-> $past(!cas_eff && !t1))
		else $error("service channel in cas or t1");
	chk_uplink_power_control_pos: assert property (ovh_uplink_power_control |-> $past(ovh_idx) == OVH_UW && $past(ovh_bit) == 3'h0)
		else $error("power control bit misplaced");
	chk_fixed_map: assert property (sat_tx.valid && $past(tx_rate) == FIXED_RATE
		|-> sat_tx.chan == 5'($past(dpos.ts) - 5'h01))
		else $error("fixed mapping broken");
	chk_buf_fallback: assert property (buf_mode == BUF_INSERT && !ins_active |=> buf_ref == REF_DEMOD)
		else $error("no fallback to demod clock");
	chk_rate_ratio: assert property (!reduced ##1 !reduced |-> sat_num == STD_NUM && sat_den == STD_DEN)
		else $error("satellite ratio wrong");

endmodule : e1dni_core

// file: hdl/e1dni_pkg.sv
/*
 * e1dni_pkg: constants, register map and carrier types for the E1/T1
 * timeslot drop-and-insert block.
 * Assumes a 25 MHz system clock and an APB register bus with 32-bit data.
 */
package e1dni_pkg;

	// register byte offsets
	localparam logic [11:0] OFS_CTRL     = 12'h000;
	localparam logic [11:0] OFS_TX_RATE  = 12'h004;
	localparam logic [11:0] OFS_RX_RATE  = 12'h008;
	localparam logic [11:0] OFS_ESC_BAUD = 12'h00C;
	localparam logic [11:0] OFS_NCO_INC  = 12'h010;
	localparam logic [11:0] OFS_STATUS   = 12'h014;
	localparam logic [11:0] OFS_ERR_CLR  = 12'h018;
	localparam logic [11:0] OFS_TX_MAP   = 12'h100;
	localparam logic [11:0] OFS_RX_MAP   = 12'h180;

	// control field positions
	localparam int CTL_DNI     = 0;
	localparam int CTL_T1      = 1;
	localparam int CTL_CAS     = 2;
	localparam int CTL_REDUCED = 3;
	localparam int CTL_LOOP    = 4;
	localparam int CTL_BUF_LO  = 5;
	localparam int CTL_HESC    = 7;
	localparam int CTL_UPLINK_POWER_CONTROL    = 8;
	localparam int CTL_X21     = 9;
	localparam int CTL_X21_DTE = 10;
	localparam int CTL_EXT_SEL = 11;
	localparam int CTL_W       = 12;

	// buffer clock modes
	localparam logic [1:0] BUF_OFF    = 2'h0;
	localparam logic [1:0] BUF_TX_EQ  = 2'h1;
	localparam logic [1:0] BUF_TX_NE  = 2'h2;
	localparam logic [1:0] BUF_INSERT = 2'h3;

	// reset values
	localparam logic [CTL_W-1:0] CTRL_RST = 12'h000;
	localparam logic [5:0]  RATE_RST    = 6'h01;
	localparam logic [2:0]  BAUD_RST    = 3'h0;
	localparam logic [15:0] NCO_INC_RST = 16'h14F8;

	// framing constants
	localparam logic [6:0] FAS_WORD   = 7'h1B;
	localparam logic [7:0] FAS_BYTE   = 8'h1B;
	localparam logic [7:0] NFAS_BYTE  = 8'h40;
	localparam logic [7:0] IDLE_BYTE  = 8'hD5;
	localparam logic [7:0] T1_LAST    = 8'hC0;
	localparam logic [5:0] FIXED_RATE = 6'h1E;
	localparam logic [5:0] MAX_E1_CH  = 6'h1F;
	localparam logic [5:0] MAX_T1_CH  = 6'h18;
	localparam logic [4:0] MAX_T1_TS  = 5'h18;

	// overhead byte positions
	localparam logic [5:0] OVH_ESC_A = 6'h10;
	localparam logic [5:0] OVH_ESC_B = 6'h30;
	localparam logic [5:0] OVH_ESC_H = 6'h20;
	localparam logic [5:0] OVH_UW    = 6'h00;

	// satellite rate ratios
	localparam logic [7:0] STD_NUM = 8'h10;
	localparam logic [7:0] STD_DEN = 8'h0F;
	localparam logic [7:0] RED_NUM = 8'h2E;
	localparam logic [7:0] RED_DEN = 8'h2D;

	// timing
	localparam int CLK_NS   = 40;
	localparam int LOSS_NS  = 2000;
	localparam int LOSS_CYC = (LOSS_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [2:0] {REF_DEMOD, REF_TXCLK, REF_EXT, REF_SYNTH, REF_INSERT} e1dni_ref_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] chan;
		logic [7:0] data;
	} e1dni_sat_t;

	typedef struct packed {
		logic [4:0] ts;
		logic [2:0] bitn;
	} e1dni_pos_t;

	typedef struct packed {
		logic       hit;
		logic [4:0] chan;
	} e1dni_hit_t;

endpackage : e1dni_pkg

// file: tb/e1dni_e1_line.sv
/*
 * e1dni_e1_line: terrestrial E1 equipment on the drop and insert pins.
 * Sends a continuous E1 stream: TS0 alternates the frame and non-frame
 * words, and every other timeslot k carries 0x40 + k; that pattern never
 * mimics the frame word across byte borders, so the framers lock cleanly.
 * Assumes the device samples data on the rising link clock edge.
 */
`timescale 1ns/100ps
module e1dni_e1_line (
	// control
	input  wire logic ins_on,
	// e1 pins
	output logic      drop_clk,
	output logic      drop_input,
	output logic      insert_clk,
	output logic      insert_input
);
	import e1dni_pkg::*;

	logic       lnk_clk = 1'b0;
	logic [7:0] bit_idx = 8'h00;
	logic       odd     = 1'b0;
	logic [7:0] cur;

	// e1 runs continuously, so the line clock never stops between frames
	initial begin
		#7;
		forever #160 lnk_clk = ~lnk_clk;
	end

	always_comb begin
		if (bit_idx[7:3] == 5'h00) begin
			cur = odd ? NFAS_BYTE : FAS_BYTE;
		end else begin
			cur = {3'h2, bit_idx[7:3]};
		end
	end

	// launch on the falling edge so data is settled at the rising edge
	initial drop_input = 1'b0;
	always @(negedge lnk_clk) begin
		drop_input <= cur[3'h7 - bit_idx[2:0]];
		if (bit_idx == 8'hFF) begin
			odd <= ~odd;
		end
		bit_idx <= bit_idx + 8'h01;
	end

	// a dead insert port shows all zeros, as after loss of signal
	assign drop_clk     = lnk_clk;
	assign insert_clk   = ins_on ? lnk_clk : 1'b0;
	assign insert_input = ins_on ? drop_input : 1'b0;

endmodule : e1dni_e1_line

// file: tb/e1_t1_timeslot_drop_insert_test.sv
/*
 * e1_t1_timeslot_drop_insert_test: register, baud cap, timeslot map,
 * overhead placement, buffer reference and drop path checks.
 * Assumes e1dni_core with APB and the e1dni_e1_line model on the pins.
 */
`timescale 1ns/100ps
module e1_t1_timeslot_drop_insert_test;
	import e1dni_pkg::*;

	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, e, ins_on = 1'b0;
	logic        buf_clk, insert_output, insert_clk_out;
	logic        drop_clk, drop_input, insert_clk, insert_input;
	logic        tx_ref_clk = 1'b0, ext_ref_clk = 1'b0, demod_tick = 1'b0;
	logic [4:0]  div = 5'h00;
	logic [5:0]  ovh_idx = 6'h00;
	logic [2:0]  ovh_bit = 3'h0;
	logic        ovh_esc, ovh_uplink_power_control;
	e1dni_ref_t  buf_ref;
	e1dni_sat_t  sat_tx;
	e1dni_sat_t  sat_rx = '0;
	logic [5:0]  rates [7] = '{6'h01, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0C, 6'h14};
	int          miscompares = 0, samples_checked = 0;

	initial begin
		forever #20 sys_clk = ~sys_clk;
	end

	// reference clocks and demod ticks derived from the system clock
	always @(posedge sys_clk) begin
		div <= div + 5'h01;
		tx_ref_clk <= div[3];
		ext_ref_clk <= div[4];
		demod_tick <= (div[2:0] == 3'h7);
	end

	e1dni_core u_dut (
		.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .drop_clk(drop_clk),
		.drop_input(drop_input), .insert_clk(insert_clk),
		.insert_input(insert_input), .drop_output(), .insert_output(insert_output),
		.insert_clk_out(insert_clk_out), .tx_ref_clk(tx_ref_clk), .ext_ref_clk(ext_ref_clk),
		.demod_tick(demod_tick), .buf_clk(buf_clk), .buf_ref(buf_ref), .sat_tx(sat_tx),
		.sat_rx(sat_rx), .ovh_idx(ovh_idx), .ovh_bit(ovh_bit),
		.ovh_esc(ovh_esc), .ovh_uplink_power_control(ovh_uplink_power_control)
	);

	e1dni_e1_line u_line (
		.ins_on(ins_on), .drop_clk(drop_clk), .drop_input(drop_input),
		.insert_clk(insert_clk), .insert_input(insert_input)
	);

	task automatic final_report;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	task automatic lim(input int n);
		if (n >= 30000) begin
			miscompares++;
			final_report();
		end
	endtask : lim

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// one apb transfer; the request is held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 30000);
		lim(n);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		cmp(q & m, x);
	endtask : rd

	task automatic ovh(input logic [11:0] c, input logic [8:0] pos, input logic [1:0] x);
		wr(OFS_CTRL, {20'h0, c});
		{ovh_idx, ovh_bit} <= pos;
		repeat (2) @(posedge sys_clk);
		cmp({30'h0, ovh_esc, ovh_uplink_power_control}, {30'h0, x});
	endtask : ovh

	// buffer reference settles within the activity timeout
	task automatic bref(input logic [11:0] c, input e1dni_ref_t x);
		wr(OFS_CTRL, {20'h0, c});
		repeat (LOSS_CYC + 10) @(posedge sys_clk);
		cmp({29'h0, buf_ref}, {29'h0, x});
	endtask : bref

	task automatic wait_ref(input e1dni_ref_t x);
		int n;
		n = 0;
		while (buf_ref !== x && n < 30000) begin
			@(posedge sys_clk);
			n++;
		end
		lim(n);
		cmp({29'h0, buf_ref}, {29'h0, x});
	endtask : wait_ref

	task automatic sat(input logic [4:0] ch, input logic [7:0] x);
		int n;
		n = 0;
		while (!(sat_tx.valid === 1'b1 && sat_tx.chan === ch) && n < 30000) begin
			@(posedge sys_clk);
			n++;
		end
		lim(n);
		cmp({24'h0, sat_tx.data}, {24'h0, x});
		@(posedge sys_clk);
	endtask : sat

	// buffer clock activity over a few reference periods
	task automatic clk_seen(input logic [11:0] c, input logic x);
		wr(OFS_CTRL, {20'h0, c});
		e = 1'b0;
		repeat (40) begin
			@(posedge sys_clk);
			e = e | buf_clk;
		end
		cmp({31'h0, e}, {31'h0, x});
	endtask : clk_seen

	// shift the insert pin on rising insert clock edges until a byte shows up
	task automatic blank(input logic [7:0] x);
		logic [7:0] sr;
		logic       ck;
		int         n;
		sr = 8'h00;
		ck = insert_clk_out;
		n = 0;
		while (sr !== x && n < 30000) begin
			@(posedge sys_clk);
			n++;
			if (insert_clk_out === 1'b1 && ck === 1'b0)
				sr = {sr[6:0], insert_output};
			ck = insert_clk_out;
		end
		lim(n);
		cmp({24'h0, sr}, {24'h0, x});
	endtask : blank

	initial begin
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rd(OFS_CTRL, 32'hFFFFFFFF, 32'h0);
		rd(OFS_TX_RATE, 32'hFFFFFFFF, 32'h1);
		rd(OFS_NCO_INC, 32'hFFFFFFFF, 32'h14F8);
		apb(1'b0, 12'h020, 32'h0);
		cmp({31'h0, e}, 32'h1);
		for (int i = 0; i < 7; i++) begin
			wr(OFS_TX_RATE, {26'h0, rates[i]});
			wr(OFS_RX_RATE, {26'h0, rates[i]});
			wr(OFS_ESC_BAUD, 32'h6);
			rd(OFS_ESC_BAUD, 32'h7, i);
		end
		wr(OFS_RX_RATE, 32'h4);
		rd(OFS_ESC_BAUD, 32'h7, 32'h2);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_TX_MAP, 32'h0);
		rd(OFS_STATUS, 32'h40, 32'h40);
		rd(OFS_TX_MAP, 32'h1F, 32'h0);
		wr(OFS_ERR_CLR, 32'h1);
		wr(OFS_TX_MAP + 12'h004, 32'h1F);
		rd(OFS_TX_MAP + 12'h004, 32'h1F, 32'h1F);
		rd(OFS_STATUS, 32'h40, 32'h0);
		wr(OFS_CTRL, 32'h3);
		wr(OFS_RX_MAP, 32'h19);
		rd(OFS_RX_MAP, 32'h1F, 32'h0);
		wr(OFS_ERR_CLR, 32'h1);
		wr(OFS_RX_MAP, 32'h18);
		rd(OFS_RX_MAP, 32'h1F, 32'h18);
		wr(OFS_RX_MAP, 32'h0);
		rd(OFS_STATUS, 32'h40, 32'h0);
		wr(OFS_CTRL, 32'h1);
		rd(OFS_STATUS, 32'hFFFF0000, 32'h0F100000);
		wr(OFS_CTRL, 32'h9);
		rd(OFS_STATUS, 32'hFFFF0000, 32'h2D2E0000);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_CTRL, 32'h81);
		ovh(12'h181, {6'h10, 3'h5}, 2'h2);
		ovh(12'h181, {6'h30, 3'h0}, 2'h2);
		ovh(12'h181, {6'h20, 3'h1}, 2'h2);
		ovh(12'h181, {6'h20, 3'h6}, 2'h0);
		ovh(12'h181, {6'h09, 3'h2}, 2'h0);
		ovh(12'h181, {6'h00, 3'h0}, 2'h1);
		ovh(12'h181, {6'h00, 3'h3}, 2'h0);
		ovh(12'h185, {6'h10, 3'h5}, 2'h0);
		ovh(12'h18D, {6'h10, 3'h5}, 2'h2);
		ovh(12'h183, {6'h10, 3'h5}, 2'h0);
		ovh(12'h183, {6'h00, 3'h0}, 2'h0);
		bref(12'h001, REF_DEMOD);
		bref(12'h021, REF_TXCLK);
		clk_seen(12'h021, 1'b1);
		clk_seen(12'h221, 1'b0);
		bref(12'h821, REF_EXT);
		bref(12'h041, REF_SYNTH);
		bref(12'h061, REF_DEMOD);
		ins_on <= 1'b1;
		wait_ref(REF_INSERT);
		ins_on <= 1'b0;
		wait_ref(REF_DEMOD);
		wr(OFS_CTRL, 32'h71);
		wait_ref(REF_INSERT);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_TX_RATE, 32'h2);
		wr(OFS_TX_MAP, 32'h3);
		wr(OFS_TX_MAP + 12'h004, 32'h1);
		wr(OFS_CTRL, 32'h1);
		sat(5'h01, 8'h41);
		sat(5'h00, 8'h43);
		wr(OFS_TX_RATE, 32'h1E);
		sat(5'h00, 8'h41);
		blank(IDLE_BYTE);
		blank(FAS_BYTE);
		final_report();
	end

endmodule : e1_t1_timeslot_drop_insert_test
